// *** include/frdly_consts.vh ***
`ifndef FRDLY_CONSTS_VH
`define FRDLY_CONSTS_VH
// register addresses on the serial control interface
`define FRDLY_ADDR_FDH 8'h20
`define FRDLY_ADDR_FDL 8'h21
`define FRDLY_ADDR_RDH 8'h22
`define FRDLY_ADDR_RDL 8'h23
// reset values
`define FRDLY_RST_FDH 8'h00
`define FRDLY_RST_FDL 8'h08
`define FRDLY_RST_RDH 8'h00
`define FRDLY_RST_RDL 8'h00
// field layout
`define FRDLY_FDL_MASK 8'h7f
`define FRDLY_RD_LOW_BITS 5
`define FRDLY_FDL_BITS 7
// reset values of the active stage, built from the shadow reset values
`define FRDLY_RST_FD 15'h0008
`define FRDLY_RST_RD 13'h0000
`define FRDLY_ZERO_BYTE 8'h00
`endif

// *** src/frdly_regs.v ***
// Behaviour
// R01: frame delay is high[7:0] then low[6:0]
// R02: host keeps frame delay at most 32767
// R03: row delay bits 12:5 from high register
// R04: all four registers readable, writable, shadowed
// R05: reset low 08 hex, high 00 hex
// R06: low register bit 7 reserved, unused
// R07: shadow copies to active at frame boundary
`include "frdly_consts.vh"

module frdly_regs
(
    input wire core_clk_in,
    input wire resetn_in,
    input wire clk_en_in,
    input wire wr_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire frame_start_in,
    output reg [7:0] rd_data_out,
    output reg [14:0] frame_delay_out,
    output reg [12:0] row_delay_out
);

    // widths of the active values and of the fields that feed them
    localparam FD_W = 15; // active frame delay width
    localparam RD_W = 13; // active row delay width
    localparam FL_W = `FRDLY_FDL_BITS; // frame delay bits in the low byte
    localparam RL_W = `FRDLY_RD_LOW_BITS; // row delay bits in the low byte

    // shadow stage written by the serial interface
    reg [7:0] frame_delay_high_r; // frame delay bits 14:7
    reg [7:0] frame_delay_low_r; // frame delay bits 6:0, msb kept zero
    reg [7:0] row_delay_high_r; // row delay bits 12:5
    reg [7:0] row_delay_low_r; // row delay low byte, stored whole

    // next values of the shadow stage
    reg [7:0] frame_delay_high_nxt; // next frame delay high byte
    reg [7:0] frame_delay_low_nxt; // next frame delay low byte
    reg [7:0] row_delay_high_nxt; // next row delay high byte
    reg [7:0] row_delay_low_nxt; // next row delay low byte

    // read mux result, registered into rd_data_out
    reg [7:0] rd_nxt;

    // next values of the active stage
    reg [FD_W-1:0] frame_delay_nxt; // assembled frame delay
    reg [RD_W-1:0] row_delay_nxt; // assembled row delay

    // a write is taken only on an enabled edge with the strobe high
    wire wr_go;
    // address matches, one per mapped register
    wire hit_fdh; // frame delay high selected
    wire hit_fdl; // frame delay low selected
    wire hit_rdh; // row delay high selected
    wire hit_rdl; // row delay low selected
    // per-register write strobes
    wire wr_fdh; // write frame delay high
    wire wr_fdl; // write frame delay low
    wire wr_rdh; // write row delay high
    wire wr_rdl; // write row delay low
    // the active stage moves only on an enabled frame boundary
    wire load_go;

    // a low clock enable blocks every strobe, so all state freezes
    assign wr_go = clk_en_in & wr_en_in;

    // address decode; any other address is neither written nor read
    assign hit_fdh = (addr_in == `FRDLY_ADDR_FDH);
    assign hit_fdl = (addr_in == `FRDLY_ADDR_FDL);
    assign hit_rdh = (addr_in == `FRDLY_ADDR_RDH);
    assign hit_rdl = (addr_in == `FRDLY_ADDR_RDL);

    // write strobes per register
    assign wr_fdh = wr_go & hit_fdh; // R04
    assign wr_fdl = wr_go & hit_fdl; // R04
    assign wr_rdh = wr_go & hit_rdh; // R04
    assign wr_rdl = wr_go & hit_rdl; // R04

    // frame boundary strobe, gated by the clock enable
    assign load_go = clk_en_in & frame_start_in; // R07

    // shadow next values; each register keeps its value unless written
    always @*
    begin
        frame_delay_high_nxt = frame_delay_high_r;
        frame_delay_low_nxt = frame_delay_low_r;
        row_delay_high_nxt = row_delay_high_r;
        row_delay_low_nxt = row_delay_low_r;
        // frame delay high byte takes the whole data byte
        if (wr_fdh)
        begin
            frame_delay_high_nxt = wr_data_in; // R04
        end
        // the reserved bit is dropped here so that it never reaches the
        // timing logic and always reads back as zero
        if (wr_fdl)
        begin
            frame_delay_low_nxt = wr_data_in & `FRDLY_FDL_MASK; // R06
        end
        // row delay high byte takes the whole data byte
        if (wr_rdh)
        begin
            row_delay_high_nxt = wr_data_in; // R04
        end
        // row low byte is kept whole since its layout is not known;
        // only its low bits feed the active row delay
        if (wr_rdl)
        begin
            row_delay_low_nxt = wr_data_in; // R04
        end
    end

    // shadow registers; reset values give a frame delay of eight
    always @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            frame_delay_high_r <= `FRDLY_RST_FDH; // R05
            frame_delay_low_r <= `FRDLY_RST_FDL; // R05
            row_delay_high_r <= `FRDLY_RST_RDH;
            row_delay_low_r <= `FRDLY_RST_RDL;
        end
        else
        begin
            // the next values already hold when nothing is written
            frame_delay_high_r <= frame_delay_high_nxt;
            frame_delay_low_r <= frame_delay_low_nxt;
            row_delay_high_r <= row_delay_high_nxt;
            row_delay_low_r <= row_delay_low_nxt;
        end
    end

    // read path shows the shadow value, unmapped addresses read zero;
    // the host reads back what it wrote, not what is active yet
    always @*
    begin
        case (addr_in)
            `FRDLY_ADDR_FDH:
            begin
                rd_nxt = frame_delay_high_r; // R04
            end
            `FRDLY_ADDR_FDL:
            begin
                rd_nxt = frame_delay_low_r; // R04
            end
            `FRDLY_ADDR_RDH:
            begin
                rd_nxt = row_delay_high_r; // R04
            end
            `FRDLY_ADDR_RDL:
            begin
                rd_nxt = row_delay_low_r; // R04
            end
            default:
            begin
                // unmapped: a plain zero keeps the bus quiet
                rd_nxt = `FRDLY_ZERO_BYTE;
            end
        endcase
    end

    // registered read data, one cycle after the address
    always @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_data_out <= `FRDLY_ZERO_BYTE;
        end
        else if (clk_en_in)
        begin
            // read data stands until the next enabled edge
            rd_data_out <= rd_nxt;
        end
    end

    // active values assembled from the shadow stage
    always @*
    begin
        // frame delay: high byte on top, seven low bits below it;
        // a value above 32767 cannot arise in a 15 bit field
        frame_delay_nxt = {frame_delay_high_r,
            frame_delay_low_r[FL_W-1:0]}; // R01
        // row delay: high byte on top, low byte lsbs below it
        row_delay_nxt = {row_delay_high_r,
            row_delay_low_r[RL_W-1:0]}; // R03
    end

    // active stage loads only at a frame start so no frame mixes
    // settings; a write on the same edge as the frame start lands in
    // the shadow and waits for the next frame start
    always @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            // must match the shadow reset values
            frame_delay_out <= `FRDLY_RST_FD; // R05
            row_delay_out <= `FRDLY_RST_RD;
        end
        else if (load_go) // R07
        begin
            frame_delay_out <= frame_delay_nxt; // R01
            row_delay_out <= row_delay_nxt; // R03
        end
    end

endmodule

// *** test/frdly_regs_properties.sv ***
module frdly_props(input wire core_clk_in, resetn_in, clk_en_in, wr_en_in,
    frame_start_in, input wire [7:0] addr_in, wr_data_in, rd_data_out,
    input wire [14:0] frame_delay_out, input wire [12:0] row_delay_out);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence ws(a, b);
        clk_en_in && wr_en_in && addr_in == a ##1 clk_en_in && b; endsequence
    fd_load_a: assert property (ws(8'h20, frame_start_in) |=>
        frame_delay_out[14:7] == $past(wr_data_in, 2)) else $error("fd");
    hold_act_a: assert property (!(frame_start_in && clk_en_in) |=>
        $stable({frame_delay_out, row_delay_out})) else $error("moved");
    rd_back_a: assert property (ws(8'h21, addr_in == 8'h21) |=>
        rd_data_out == ($past(wr_data_in, 2) & 8'h7f)) else $error("rd");
    row_load_a: assert property (ws(8'h22, frame_start_in) |=>
        row_delay_out[12:5] == $past(wr_data_in, 2)) else $error("row");
    unmapped_zero_a: assert property (clk_en_in && addr_in == 8'h24 |=>
        rd_data_out == 8'h00) else $error("unmapped");
    freeze_a: assert property (!clk_en_in |=>
        $stable({rd_data_out, frame_delay_out, row_delay_out}))
        else $error("frozen");
    reset_value_a: assert property (disable iff (1'b0)
        !resetn_in [*2] |-> frame_delay_out == 15'h0008 &&
        row_delay_out == 13'h0000 && rd_data_out == 8'h00)
        else $error("reset");
    cover property (!clk_en_in && wr_en_in && frame_start_in);
    cover property (ws(8'h20, frame_start_in));
    cover property (ws(8'h24, 1'b1));
    cover property ($rose(resetn_in));
endmodule

// *** test/testbench.sv ***
module testbench;
    timeunit 1ns / 1ns;
    logic core_clk_in = 0, resetn_in = 0, clk_en_in = 1, wr_en_in = 0;
    logic frame_start_in = 0;
    logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out;
    logic [14:0] frame_delay_out;
    logic [12:0] row_delay_out;
    int errors = 0, num_checks = 0;
    // frame mark, address, data, read back; 24 hex is unmapped
    // frame values stay within 15 bits, so never above 32767
    logic [24:0] rows [6] = '{25'h021ff7f, 25'h022a5a5, 25'h0231f1f,
        25'h0245500, 25'h1201212, 25'h1223333};
    frdly_regs i_dut(.*);
    always #25 core_clk_in = ~core_clk_in;
    task chk(input [14:0] s, e, input string n);
        num_checks++;
        errors += (s !== e);
        if (s !== e)
            $display("mismatch %s exp %h got %h", n, e, s);
    endtask
    // read one register: address on one edge, data after the next
    task rd(input [7:0] a, e);
        @(posedge core_clk_in);
        addr_in <= a;
        @(posedge core_clk_in);
        #1 chk(rd_data_out, e, "rd");
    endtask
    task print_verdict(input int late);
        errors += late;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a hang past this span counts as a mismatch
    initial #20us print_verdict(1);
    initial
    begin
        repeat (3) @(posedge core_clk_in);
        resetn_in <= 1;
        foreach (rows[i])
        begin
            @(posedge core_clk_in);
            {addr_in, wr_data_in, wr_en_in} <= {rows[i][23:8], 1'b1};
            @(posedge core_clk_in);
            {wr_en_in, frame_start_in} <= {1'b0, rows[i][24]};
            @(posedge core_clk_in);
            frame_start_in <= 0;
            #1 chk(rd_data_out, rows[i][7:0], "rd");
        end
        chk(row_delay_out, 15'h067f, "row");
        chk(frame_delay_out, 15'h097f, "frame");
        $display("rows done");
        // write and frame mark on one edge: the old shadow goes active
        @(posedge core_clk_in);
        {addr_in, wr_data_in, wr_en_in} <= {8'h20, 8'h05, 1'b1};
        frame_start_in <= 1;
        @(posedge core_clk_in);
        wr_en_in <= 0;
        #1 chk(frame_delay_out, 15'h097f, "same");
        @(posedge core_clk_in);
        frame_start_in <= 0;
        #1 chk(frame_delay_out, 15'h02ff, "next");
        $display("same edge done");
        // clock enable low: a write and a frame mark are both lost
        @(posedge core_clk_in);
        clk_en_in <= 0;
        {wr_en_in, wr_data_in, frame_start_in} <= {1'b1, 8'h77, 1'b1};
        @(posedge core_clk_in);
        {clk_en_in, wr_en_in, frame_start_in} <= 3'b100;
        @(posedge core_clk_in);
        #1 chk(rd_data_out, 15'h0005, "frozen rd");
        chk(frame_delay_out, 15'h02ff, "frozen");
        $display("freeze done");
        resetn_in <= 0;
        #1 chk(frame_delay_out, 15'h0008, "rst");
        chk(row_delay_out, 15'h0000, "rst row");
        chk(rd_data_out, 15'h0000, "rst rd");
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1;
        rd(8'h21, 8'h08);
        rd(8'h20, 8'h00);
        $display("reset done");
        print_verdict(0);
    end
endmodule
bind frdly_regs frdly_props i_chk(.*);
